//--- design/sstc_ctrl.sv
// Host controller that drives split transfers, stop points and serial shifting.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module sstc_ctrl #(
    parameter int GUARD = sstc_pkg::SPLIT_GUARD
) (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    output sstc_pkg::sstc_pins_t   vram,
    input  wire logic              active_half_flag
);
    // ****************************************
    // Register bus
    // ****************************************
    sstc_pkg::sstc_state_t state;
    logic [8:0]  row_addr;
    logic [8:0]  col_addr;
    logic [2:0]  stop_sel;
    logic [15:0] shift_left;
    logic [2:0]  cmd;
    logic        busy;
    logic        full_done;
    logic        refused;
    logic        split_pending;
    logic [7:0]  split_tap;
    logic [8:0]  shadow;
    logic [2:0]  flag_sync;
    logic        flag_seen;
    logic [7:0]  phase;
    logic        phase_end;
    logic        wr_take;
    logic        start_cmd;
    logic        start_shift;
    logic        near_edge;
    logic        split_bad;
    logic        mapped;
    logic [7:0]  stop_armed;
    logic [7:0]  stop_live;

    assign wr_take   = psel && penable && pready && pwrite;
    assign phase_end = (phase == 8'(sstc_pkg::PHASE_CYCLES - 1));
    assign mapped    = (paddr == sstc_pkg::OFF_CMD) || (paddr == sstc_pkg::OFF_ADDR) ||
                       (paddr == sstc_pkg::OFF_STOP) || (paddr == sstc_pkg::OFF_SHIFT) ||
                       (paddr == sstc_pkg::OFF_STATUS);
    assign start_cmd   = wr_take && (paddr == sstc_pkg::OFF_CMD) && !busy;
    assign start_shift = wr_take && (paddr == sstc_pkg::OFF_SHIFT) && !busy &&
                         (pwdata[15:0] != 16'h0000);
    assign near_edge = (shadow[7:0] > 8'(255 - GUARD)) || (shadow[7:0] < 8'(GUARD));
    assign split_bad = !full_done || near_edge;
    assign busy      = (state != sstc_pkg::ST_IDLE);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                unique case (paddr)
                    sstc_pkg::OFF_ADDR: begin
                        prdata <= {7'h00, col_addr, 7'h00, row_addr};
                    end
                    sstc_pkg::OFF_STOP: begin
                        prdata <= {29'h0000_0000, stop_sel};
                    end
                    sstc_pkg::OFF_SHIFT: begin
                        prdata <= {16'h0000, shift_left};
                    end
                    sstc_pkg::OFF_STATUS: begin
                        prdata <= {7'h00, shadow, 11'h000, split_pending, refused,
                                   full_done, flag_seen, busy};
                    end
                    default: begin
                        prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            row_addr <= sstc_pkg::ADDR_RESET;
            col_addr <= sstc_pkg::ADDR_RESET;
            stop_sel <= sstc_pkg::STOP_RESET;
        end else if (wr_take && !busy) begin
            if (paddr == sstc_pkg::OFF_ADDR) begin
                row_addr <= pwdata[sstc_pkg::ADDR_ROW_LSB +: 9];
                col_addr <= pwdata[sstc_pkg::ADDR_COL_LSB +: 9];
            end
            if (paddr == sstc_pkg::OFF_STOP && pwdata[2:0] <= sstc_pkg::STOP_SEL_MAX) begin
                stop_sel <= pwdata[2:0];
            end
        end
    end

    // ****************************************
    // Half flag input
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            flag_sync <= 3'h0;
            flag_seen <= 1'b0;
        end else begin
            flag_sync <= {flag_sync[1:0], active_half_flag};
            if (flag_sync[1] == flag_sync[2]) begin
                flag_seen <= flag_sync[2];
            end
        end
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state      <= sstc_pkg::ST_IDLE;
            phase      <= 8'h00;
            cmd        <= 3'h0;
            refused    <= 1'b0;
            shift_left <= 16'h0000;
        end else begin
            phase <= phase_end ? 8'h00 : phase + 8'h01;
            unique case (state)
                sstc_pkg::ST_IDLE: begin
                    phase <= 8'h00;
                    if (start_cmd) begin
                        cmd <= pwdata[2:0];
                        if (pwdata[2:0] == sstc_pkg::CMD_SPLIT && split_bad) begin
                            refused <= 1'b1;
                        end else if (pwdata[2:0] >= sstc_pkg::CMD_FULL &&
                                     pwdata[2:0] <= sstc_pkg::CMD_REFRESH) begin
                            refused <= 1'b0;
                            state   <= sstc_pkg::ST_SETUP;
                        end else begin
                            refused <= 1'b1;
                        end
                    end else if (start_shift) begin
                        shift_left <= pwdata[15:0];
                        state      <= sstc_pkg::ST_SC_HI;
                    end
                end
                sstc_pkg::ST_SETUP: begin
                    if (phase_end) begin
                        state <= sstc_pkg::ST_ROW;
                    end
                end
                sstc_pkg::ST_ROW: begin
                    if (phase_end) begin
                        state <= (cmd == sstc_pkg::CMD_FULL || cmd == sstc_pkg::CMD_SPLIT) ?
                                 sstc_pkg::ST_COL : sstc_pkg::ST_XFER;
                    end
                end
                sstc_pkg::ST_COL: begin
                    if (phase_end) begin
                        state <= sstc_pkg::ST_XFER;
                    end
                end
                sstc_pkg::ST_XFER: begin
                    if (phase_end) begin
                        state <= sstc_pkg::ST_REL;
                    end
                end
                sstc_pkg::ST_REL: begin
                    if (phase_end) begin
                        state <= sstc_pkg::ST_IDLE;
                    end
                end
                sstc_pkg::ST_SC_HI: begin
                    if (phase_end) begin
                        shift_left <= shift_left - 16'h0001;
                        state      <= sstc_pkg::ST_SC_LO;
                    end
                end
                sstc_pkg::ST_SC_LO: begin
                    if (phase_end) begin
                        state <= (shift_left == 16'h0000) ? sstc_pkg::ST_IDLE :
                                 sstc_pkg::ST_SC_HI;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    // Row levels are set one phase ahead of the row strobe, while the column address moves on the same edge as
    // the column strobe, so the memory always sees stable setup at the falling row strobe.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            vram <= sstc_pkg::PINS_IDLE;
        end else begin
            vram <= sstc_pkg::PINS_IDLE;
            unique case (state)
                sstc_pkg::ST_SETUP, sstc_pkg::ST_ROW: begin
                    vram.row_strobe_n <= (state == sstc_pkg::ST_SETUP);
                    if (cmd == sstc_pkg::CMD_FULL || cmd == sstc_pkg::CMD_SPLIT) begin
                        vram.addr                     <= row_addr;
                        vram.transfer_output_enable_n <= 1'b0;
                        vram.mask_write_enable        <= 1'b1;
                        vram.special_function_select  <= (cmd == sstc_pkg::CMD_SPLIT);
                    end else begin
                        vram.col_strobe_n <= 1'b0;
                        vram.special_function_select <= (cmd != sstc_pkg::CMD_OPTRST);
                        vram.lower_byte_write_enable_n <= (cmd != sstc_pkg::CMD_STOPSET);
                        vram.addr <= {1'b0, sstc_pkg::STOP_CODE[stop_sel], 4'h0};
                    end
                end
                sstc_pkg::ST_COL, sstc_pkg::ST_XFER: begin
                    vram.row_strobe_n             <= 1'b0;
                    vram.col_strobe_n             <= 1'b0;
                    vram.transfer_output_enable_n <= (state == sstc_pkg::ST_XFER) ||
                        !(cmd == sstc_pkg::CMD_FULL || cmd == sstc_pkg::CMD_SPLIT);
                    vram.addr <= (cmd == sstc_pkg::CMD_SPLIT) ? {1'b0, col_addr[7:0]} :
                                 col_addr;
                end
                sstc_pkg::ST_SC_HI: begin
                    vram.serial_shift_strobe <= 1'b1;
                end
                default: begin
                    vram <= sstc_pkg::PINS_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Stop point tracking
    // ****************************************
    // A programmed stop point only steers the mirror after the next split, while an
    // option reset returns to the half edges at once. The mask has ones over the
    // location bits inside one partition.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            stop_armed <= sstc_pkg::HALF_LAST;
            stop_live  <= sstc_pkg::HALF_LAST;
        end else if (state == sstc_pkg::ST_REL && phase_end) begin
            if (cmd == sstc_pkg::CMD_STOPSET) begin
                stop_armed <= {sstc_pkg::STOP_CODE[stop_sel], 4'hf};
            end else if (cmd == sstc_pkg::CMD_OPTRST) begin
                stop_armed <= sstc_pkg::HALF_LAST;
                stop_live  <= sstc_pkg::HALF_LAST;
            end else if (cmd == sstc_pkg::CMD_SPLIT) begin
                stop_live <= stop_armed;
            end
        end
    end

    // ****************************************
    // Serial address mirror
    // ****************************************
    // The mirror jumps at the live stop point once a split is pending. The guard
    // window covers only the 255 and 511 edges, so a split close to an inner stop
    // point is left to the user to avoid.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            shadow        <= sstc_pkg::ADDR_RESET;
            full_done     <= 1'b0;
            split_pending <= 1'b0;
            split_tap     <= 8'h00;
        end else if (state == sstc_pkg::ST_REL && phase_end &&
                     cmd == sstc_pkg::CMD_FULL) begin
            shadow        <= col_addr;
            full_done     <= 1'b1;
            split_pending <= 1'b0;
        end else if (state == sstc_pkg::ST_REL && phase_end &&
                     cmd == sstc_pkg::CMD_SPLIT) begin
            split_tap     <= col_addr[7:0];
            split_pending <= 1'b1;
        end else if (state == sstc_pkg::ST_SC_HI && phase == 8'h00) begin
            if ((shadow[7:0] & stop_live) == stop_live && split_pending) begin
                shadow        <= {~shadow[8], split_tap};
                split_pending <= 1'b0;
            end else begin
                shadow <= shadow + 9'h001;
            end
        end
    end
endmodule : sstc_ctrl

//--- design/sstc_pkg.sv
// Constants, codes and pin bundle of the split serial transfer controller.
package sstc_pkg;
    // ****************************************
    // Register map and fields
    // ****************************************
    localparam logic [7:0] OFF_CMD     = 8'h00;
    localparam logic [7:0] OFF_ADDR    = 8'h04;
    localparam logic [7:0] OFF_STOP    = 8'h08;
    localparam logic [7:0] OFF_SHIFT   = 8'h0c;
    localparam logic [7:0] OFF_STATUS  = 8'h10;
    localparam int         ADDR_ROW_LSB = 0;
    localparam int         ADDR_COL_LSB = 16;
    localparam int         ST_BUSY      = 0;
    localparam int         ST_FLAG      = 1;
    localparam int         ST_FULLDONE  = 2;
    localparam int         ST_REFUSED   = 3;
    localparam int         ST_PENDING   = 4;
    localparam int         ST_SHADOW    = 16;
    localparam logic [8:0] ADDR_RESET   = 9'h000;
    localparam logic [2:0] STOP_RESET   = 3'h0;
    // ****************************************
    // Commands and stop codes
    // ****************************************
    localparam logic [2:0] CMD_FULL    = 3'h1;
    localparam logic [2:0] CMD_SPLIT   = 3'h2;
    localparam logic [2:0] CMD_STOPSET = 3'h3;
    localparam logic [2:0] CMD_OPTRST  = 3'h4;
    localparam logic [2:0] CMD_REFRESH = 3'h5;
    localparam logic [2:0] STOP_SEL_MAX = 3'h4;
    localparam logic [3:0] STOP_CODE [5] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h0};
    localparam logic [7:0] HALF_LAST   = 8'hff;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_NS       = 100;
    localparam int T_PHASE_NS   = 100;
    localparam int PHASE_CYCLES = (T_PHASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SPLIT_GUARD  = 4;

    typedef enum {
        ST_IDLE, ST_SETUP, ST_ROW, ST_COL, ST_XFER, ST_REL, ST_SC_HI, ST_SC_LO
    } sstc_state_t;

    typedef struct packed {
        logic       row_strobe_n;
        logic       col_strobe_n;
        logic       transfer_output_enable_n;
        logic       mask_write_enable;
        logic       lower_byte_write_enable_n;
        logic       upper_byte_write_enable_n;
        logic       special_function_select;
        logic       serial_shift_strobe;
        logic [8:0] addr;
    } sstc_pins_t;

    localparam sstc_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0,
                                         9'h000};
endpackage : sstc_pkg

//--- testbench/sstc_ctrl_assertions.sv
// Port-level checks of the split serial transfer controller.
`timescale 1ns/1ps
// ****
// Checker
// ****
module sstc_ctrl_assertions #(
    parameter int GUARD = 4
) (
    input wire logic                 clk_sys,
    input wire logic                 nrst,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire logic [31:0]          prdata,
    input wire logic                 pslverr,
    input wire sstc_pkg::sstc_pins_t vram,
    input wire logic                 active_half_flag
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    a_ready_after_access: assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held");
    a_error_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error answer");
    a_pins_idle_release: assert property ($rose(nrst) |-> vram == sstc_pkg::PINS_IDLE)
        else $error("pins not idle");
    a_transfer_pin_levels: assert property ($fell(vram.row_strobe_n) && vram.col_strobe_n
        |-> !vram.transfer_output_enable_n && vram.mask_write_enable)
        else $error("transfer levels wrong");
    a_split_col_msb: assert property ($fell(vram.col_strobe_n) && !vram.row_strobe_n
        && $past(vram.special_function_select) |-> !vram.addr[8])
        else $error("split column msb set");
    a_refresh_col_first: assert property ($fell(vram.row_strobe_n) && !vram.col_strobe_n
        |-> $past(vram.col_strobe_n) == 1'b0)
        else $error("column strobe not first");
    a_stop_code_legal: assert property ($fell(vram.row_strobe_n) && !vram.col_strobe_n
        && !vram.lower_byte_write_enable_n |-> vram.special_function_select
        && vram.addr[7:4] inside {4'hf, 4'h7, 4'h3, 4'h1, 4'h0})
        else $error("stop code illegal");
    a_shift_one_pulse: assert property (vram.serial_shift_strobe
        |-> vram.row_strobe_n ##1 !vram.serial_shift_strobe)
        else $error("shift pulse wrong");

    c_split: cover property ($fell(vram.row_strobe_n) && vram.col_strobe_n
        && vram.special_function_select);
    c_error: cover property (pslverr);
    c_flag_up: cover property ($rose(active_half_flag));
endmodule : sstc_ctrl_assertions

bind sstc_ctrl sstc_ctrl_assertions #(.GUARD(GUARD)) u_chk (.clk_sys(clk_sys), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .vram(vram),
    .active_half_flag(active_half_flag));

//--- testbench/sstc_ctrl_bench.sv
// Self-checking bench of the split serial transfer controller.
`timescale 1ns/1ps
// ****
// Bench
// ****
module sstc_ctrl_bench;
    logic                 clk_sys = 1'b0;
    logic                 nrst = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [7:0]           paddr = 8'h00;
    logic [31:0]          pwdata = 32'h0;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    sstc_pkg::sstc_pins_t vram;
    logic                 active_half_flag;
    int                   fail_count = 0;
    int                   compares = 0;
    int                   cyc = 0;
    logic [31:0]          lfsr = 32'h7067dd7f;
    logic [31:0]          rd;
    logic                 er;
    logic [7:0]           y;
    logic [8:0]           col;
    logic [2:0]           bad [3] = '{3'h0, 3'h6, 3'h7};

    initial forever #50 clk_sys = ~clk_sys;

    sstc_ctrl i_dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .vram(vram), .active_half_flag(active_half_flag));
    sstc_vram_model i_mem (.vram(vram), .active_half_flag(active_half_flag));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [31:0] st(input logic f, input logic d, input logic r,
                                       input logic p, input logic [8:0] m);
        return {7'h0, m, 11'h0, p, r, d, f, 1'b0};
    endfunction : st

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic final_report();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // The request is held until pready is seen; an idle edge follows so no pin moves twice.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    // Writes, polls busy, then lets the three-stage flag synchroniser settle.
    task automatic go(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
        for (int n = 0; n < 1000; n++) begin
            apb(1'b0, sstc_pkg::OFF_STATUS, 32'h0, rd, er);
            if (rd[0] === 1'b0) break;
        end
        repeat (4) @(posedge clk_sys);
    endtask : go

    task automatic stat(input string nm, input logic [31:0] e);
        apb(1'b0, sstc_pkg::OFF_STATUS, 32'h0, rd, er);
        chk(nm, rd, e);
    endtask : stat

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        stat("status_reset", st(1'b0, 1'b0, 1'b0, 1'b0, 9'h000));
        for (int i = 1; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, rd, er);
            chk("reg_reset", rd, 32'h0);
        end
        apb(1'b1, 8'h14, 32'h1, rd, er);
        chk("unmapped_wr", {31'h0, er}, 32'h1);
        apb(1'b0, 8'h14, 32'h0, rd, er);
        chk("unmapped_rd", rd, 32'h0);
        go(sstc_pkg::OFF_CMD, {29'h0, sstc_pkg::CMD_SPLIT});
        stat("split_first", st(1'b0, 1'b0, 1'b1, 1'b0, 9'h000));
        foreach (bad[k]) begin
            go(sstc_pkg::OFF_CMD, {29'h0, bad[k]});
            stat("bad_cmd", st(1'b0, 1'b0, 1'b1, 1'b0, 9'h000));
        end
        lfsr = lfsr_next(lfsr);
        col = lfsr[8:0];
        go(sstc_pkg::OFF_ADDR, {7'h0, col, 7'h0, lfsr[31:23]});
        go(sstc_pkg::OFF_CMD, {29'h0, sstc_pkg::CMD_FULL});
        stat("full_rand", st(col[8], 1'b1, 1'b0, 1'b0, col));
        go(sstc_pkg::OFF_ADDR, {23'h0, lfsr[24:16]});
        go(sstc_pkg::OFF_CMD, {29'h0, sstc_pkg::CMD_FULL});
        go(sstc_pkg::OFF_SHIFT, 32'h10);
        stat("shift16", st(1'b0, 1'b1, 1'b0, 1'b0, 9'h010));
        for (int i = 0; i < 2; i++) begin
            lfsr = lfsr_next(lfsr);
            y = lfsr[7:0];
            go(sstc_pkg::OFF_ADDR, {7'h0, 1'b1, y, 16'h0});
            go(sstc_pkg::OFF_CMD, {29'h0, sstc_pkg::CMD_SPLIT});
            stat("split_pend", st(1'b0, 1'b1, 1'b0, 1'b1, 9'h010));
        end
        go(sstc_pkg::OFF_SHIFT, 32'hf0);
        stat("boundary", st(1'b1, 1'b1, 1'b0, 1'b0, {1'b1, y}));
        go(sstc_pkg::OFF_SHIFT, 32'h100 - {24'h0, y});
        stat("wrap", st(1'b0, 1'b1, 1'b0, 1'b0, 9'h000));
        go(sstc_pkg::OFF_CMD, {29'h0, sstc_pkg::CMD_SPLIT});
        stat("guard", st(1'b0, 1'b1, 1'b1, 1'b0, 9'h000));
        for (int i = 0; i < 6; i++) begin
            go(sstc_pkg::OFF_STOP, 32'(i));
            apb(1'b0, sstc_pkg::OFF_STOP, 32'h0, rd, er);
            chk("stop_sel", rd, (i < 5) ? 32'(i) : 32'h4);
            go(sstc_pkg::OFF_CMD, {29'h0, sstc_pkg::CMD_STOPSET});
            stat("stop_set", st(1'b0, 1'b1, 1'b0, 1'b0, 9'h000));
        end
        go(sstc_pkg::OFF_CMD, {29'h0, sstc_pkg::CMD_OPTRST});
        stat("opt_reset", st(1'b0, 1'b1, 1'b0, 1'b0, 9'h000));
        go(sstc_pkg::OFF_CMD, {29'h0, sstc_pkg::CMD_REFRESH});
        stat("refresh", st(1'b0, 1'b1, 1'b0, 1'b0, 9'h000));
        go(sstc_pkg::OFF_STOP, 32'h1);
        go(sstc_pkg::OFF_CMD, {29'h0, sstc_pkg::CMD_STOPSET});
        go(sstc_pkg::OFF_SHIFT, 32'h10);
        lfsr = lfsr_next(lfsr);
        y = lfsr[15:8];
        go(sstc_pkg::OFF_ADDR, {7'h0, 1'b1, y, 16'h0});
        go(sstc_pkg::OFF_CMD, {29'h0, sstc_pkg::CMD_SPLIT});
        go(sstc_pkg::OFF_SHIFT, 32'h70);
        stat("stop_jump", st(1'b1, 1'b1, 1'b0, 1'b0, {1'b1, y}));
        final_report();
    end
endmodule : sstc_ctrl_bench

//--- testbench/sstc_vram_model.sv
// Behavioural model of the video memory serial buffer and its half flag.
`timescale 1ns/1ps
// ****
// Model
// ****
module sstc_vram_model (
    input wire sstc_pkg::sstc_pins_t vram,
    output logic                     active_half_flag
);
    logic [8:0] ptr = 9'h000;
    logic [8:0] tap = 9'h000;
    logic       pend = 1'b0;
    logic       xfer = 1'b0;
    logic       split = 1'b0;
    logic [7:0] stop_armed = 8'hff;
    logic [7:0] stop_live = 8'hff;

    initial active_half_flag = 1'b0;
    // Pins are read 1 ns late, since fields of the bundle may update one after another.
    always @(negedge vram.row_strobe_n) begin
        #1;
        xfer = vram.col_strobe_n && !vram.transfer_output_enable_n;
        split = vram.special_function_select && vram.mask_write_enable;
        if (!vram.col_strobe_n && !vram.special_function_select) begin
            stop_armed = 8'hff;
            stop_live = 8'hff;
        end else if (!vram.col_strobe_n &&
                     !(vram.lower_byte_write_enable_n && vram.upper_byte_write_enable_n)) begin
            stop_armed = {vram.addr[7:4], 4'hf};
        end
    end
    always @(negedge vram.col_strobe_n) begin
        #1;
        if (!vram.row_strobe_n && xfer && split) begin
            tap = {~active_half_flag, vram.addr[7:0]};
            pend = 1'b1;
            stop_live = stop_armed;
        end else if (!vram.row_strobe_n && xfer) begin
            ptr = vram.addr;
            active_half_flag = vram.addr[8];
            pend = 1'b0;
        end
    end
    always @(posedge vram.serial_shift_strobe) begin
        if ((ptr[7:0] & stop_live) == stop_live && pend) begin
            active_half_flag = ~active_half_flag;
            ptr = tap;
            pend = 1'b0;
        end else if (ptr[7:0] == 8'hff) begin
            active_half_flag = ~active_half_flag;
            ptr = ptr + 9'h001;
        end else begin
            ptr = ptr + 9'h001;
        end
    end
endmodule : sstc_vram_model
